// *** core/sba_pkg.sv ***
// Purpose: Shared constants, types and helpers of the system bus arbiter.
// Assumes: Eleven physical initiators, fourteen regions, four permission groups.
// Notes:   Register offsets are byte addresses on the plain register port.
package sba_pkg;

    // ****************************************************************
    // Sizes
    // ****************************************************************
    localparam int NUM_PORTS   = 11;  // Physical initiator ports
    localparam int NUM_REGIONS = 14;  // Target regions
    localparam int NUM_GROUPS  = 4;   // Permission groups 0..3
    localparam int GRP_W       = 2;   // Width of a group number
    localparam int ID_W        = 4;   // Width of an initiator identifier
    localparam int ADDR_W      = 32;  // System bus address width
    localparam int REG_AW      = 8;   // Register port address width
    localparam int REGION_LSB  = 28;  // Region number sits in the top nibble

    // ****************************************************************
    // Initiator ports and identifiers
    // ****************************************************************
    localparam int P_CPU   = 0;
    localparam int P_DMAR  = 1;
    localparam int P_DMAW  = 2;
    localparam int P_FLASH = 9;
    // Normal identifiers, port 10 down to port 0
    localparam logic [NUM_PORTS-1:0][ID_W-1:0] ID_NORMAL = {
        4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3, 4'h1};
    localparam logic [ID_W-1:0] ID_HIGH_STEP = 4'h1;  // High identifier = normal + 1
    localparam logic [3:0]      SRAM_REGION  = 4'h0;  // Region that holds SRAM

    // ****************************************************************
    // Register map and fields
    // ****************************************************************
    localparam logic [REG_AW-1:0] OFS_CONFIG = 8'h00;  // system_config_register
    localparam logic [REG_AW-1:0] OFS_UNLOCK = 8'h04;  // Unlock key port
    localparam logic [REG_AW-1:0] OFS_GROUP  = 8'h08;  // permission_group_assign_register
    localparam logic [REG_AW-1:0] OFS_STATUS = 8'h0c;  // Violation status
    localparam logic [REG_AW-1:0] OFS_REGION = 8'h40;  // First region access mask
    localparam int CFG_DMA_PRI_BIT = 25;  // dma_sram_priority_select
    localparam int CFG_CPU_PRI_BIT = 24;  // cpu_sram_priority_select
    localparam int CFG_LOCK_BIT    = 11;  // permission_lock_bit
    localparam int ST_VIOL_BIT     = 0;   // Sticky violation flag
    localparam int ST_ID_LSB       = 8;   // Identifier of last violator
    localparam int ST_OPEN_BIT     = 16;  // Lock bit change armed
    localparam logic [31:0] UNLOCK_KEY1 = 32'haa996655;
    localparam logic [31:0] UNLOCK_KEY2 = 32'h556699aa;
    localparam logic [NUM_GROUPS-1:0] REGION_MASK_RST = 4'hf;  // All groups allowed

    // Unlock sequence progress
    typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_OPEN} sba_unlock_t;

    // Region number of an address; values of NUM_REGIONS and up hit nothing
    function automatic logic [3:0] region_of(input logic [ADDR_W-1:0] addr);
        region_of = addr[ADDR_W-1:REGION_LSB];
    endfunction

endpackage

// *** core/sba_perm_if.sv ***
// Purpose: Carries one access from the arbiter to the permission check.
// Assumes: One access is checked per cycle.
// Notes:   Purely combinational signals.
`timescale 1ns/100ps
interface sba_perm_if;
    import sba_pkg::*;
    logic [ADDR_W-1:0]                       addr;   // Address of granted access
    logic [GRP_W-1:0]                        group;  // Group of granted initiator
    logic [NUM_REGIONS-1:0][NUM_GROUPS-1:0]  masks;  // Per-region allowed groups
    logic                                    allow;  // Access may reach target

    modport arb (output addr, output group, output masks, input allow);
    modport chk (input addr, input group, input masks, output allow);
endinterface

// *** core/sba_perm_check.sv ***
// Purpose: Decides whether the granted access may reach its target region.
// Assumes: Region number is the top address nibble.
// Notes:   Addresses above the last region are refused like a violation.
`timescale 1ns/100ps
module sba_perm_check
    import sba_pkg::*;
(
    // Access under test
    sba_perm_if.chk pif
);

    // ****************************************************************
    // Region decode and group test
    // ****************************************************************
    logic [3:0] region;  // Addressed region
    logic       hit;     // Region exists

    assign region = region_of(pif.addr);
    assign hit    = (32'(region) < NUM_REGIONS);

    // Each group owns its own bit, so a region can be exclusive or shared
    always_comb begin
        pif.allow = 1'b0;
        if (hit) begin
            pif.allow = pif.masks[region][pif.group];
        end
    end

endmodule

// *** core/sba_bus_arbiter.sv ***
// Purpose: System bus arbiter with least-recently-served order, a high
//          class of flash plus, for SRAM, CPU (in an exception) and DMA by select bit, and group based region protection.
// Assumes: Initiators are logic on clk_in; each holds its request until granted.
// Notes:   Grant is combinational; access results follow one cycle later.
`timescale 1ns/100ps

module sba_bus_arbiter
    import sba_pkg::*;
#(
    parameter int PORTS = NUM_PORTS  // Initiator ports served
)(
    // Clock and reset
    input  wire logic                              clk_in,
    input  wire logic                              rst_in,
    // Initiator requests
    input  wire logic [PORTS-1:0]                  req_in,
    input  wire logic [PORTS-1:0][ADDR_W-1:0]      addr_in,
    input  wire logic                              exl_in,
    // Arbitration result
    output logic      [PORTS-1:0]                  grant_out,
    output logic      [ID_W-1:0]                   grant_id_out,
    output logic                                   target_valid_out,
    output logic      [ADDR_W-1:0]                 target_addr_out,
    output logic                                   violation_out,
    // Register port
    input  wire logic [REG_AW-1:0]                 reg_addr_in,
    input  wire logic [31:0]                       reg_wdata_in,
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    output logic      [31:0]                       reg_rdata_out
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Identifier table and group register are laid out for eleven ports
    generate
        if (PORTS != NUM_PORTS) begin : g_bad_ports
            $error("sba_bus_arbiter supports exactly NUM_PORTS initiators");
        end
        // Package sizes must fit the fields that carry them
        if (NUM_REGIONS > (1 << (ADDR_W - REGION_LSB))) begin : g_bad_regions
            $error("sba_bus_arbiter region field too narrow");
        end
        if (NUM_GROUPS > (1 << GRP_W)) begin : g_bad_groups
            $error("sba_bus_arbiter group field too narrow");
        end
        // All group fields share one register word
        if (PORTS * GRP_W > 32) begin : g_bad_group_word
            $error("sba_bus_arbiter group word too narrow");
        end
        // Winner index is four bits wide
        if (PORTS > 16) begin : g_bad_index
            $error("sba_bus_arbiter winner index too narrow");
        end
    endgenerate

    // ****************************************************************
    // State
    // ****************************************************************
    // One record for all state, so reset and next
    // state cannot drift apart
    typedef struct packed {
        logic [PORTS-1:0][PORTS-1:0]            older;       // older[i][j]: i waited longer
        logic                                   dma_pri;     // dma_sram_priority_select
        logic                                   cpu_pri;     // cpu_sram_priority_select
        logic                                   lock;        // permission_lock_bit
        sba_unlock_t                            unl;         // Unlock sequence progress
        logic [PORTS-1:0][GRP_W-1:0]            group;       // Group per initiator
        logic [NUM_REGIONS-1:0][NUM_GROUPS-1:0] masks;       // Allowed groups per region
        logic [ID_W-1:0]                        gid;         // Identifier of last grant
        logic                                   tvalid;      // Access passed to target
        logic [ADDR_W-1:0]                      taddr;       // Address passed to target
        logic                                   viol;        // Violation pulse
        logic                                   viol_sticky; // Violation seen
        logic [ID_W-1:0]                        viol_id;     // Last violator
        logic [31:0]                            rdata;       // Read answer
    } sba_arb_state_t;

    sba_arb_state_t s_q;  // Registered state
    sba_arb_state_t s_d;  // Next state

    // Arbitration signals
    // These settle within the cycle
    logic [PORTS-1:0] high;     // Request belongs to the high class
    logic [PORTS-1:0] cand;     // Requests allowed to compete this cycle
    logic [PORTS-1:0] win;      // One-hot winner
    logic [3:0]       win_idx;  // Winner port number
    logic             any_win;  // Some request granted

    // Permission check link
    sba_perm_if pif ();

    // ****************************************************************
    // Class of each request
    // ****************************************************************
    // Only CPU and DMA move between classes, and only for SRAM;
    // flash sits in the high class for good
    always_comb begin
        high = '0;
        // Flash never leaves the high class
        high[P_FLASH] = 1'b1;
        // CPU rises only in an exception, for SRAM
        if (region_of(addr_in[P_CPU]) == SRAM_REGION) begin
            high[P_CPU] = exl_in & s_q.cpu_pri;
        end
        // Both DMA directions share one select bit
        if (region_of(addr_in[P_DMAR]) == SRAM_REGION) begin
            high[P_DMAR] = s_q.dma_pri;
        end
        if (region_of(addr_in[P_DMAW]) == SRAM_REGION) begin
            high[P_DMAW] = s_q.dma_pri;
        end
    end

    // ****************************************************************
    // Winner selection
    // ****************************************************************
    // A waiting high request shuts the normal class out entirely.
    // The age matrix then picks the one that waited longest; this order
    // has no software control at all.
    // Limitation: a steady high stream starves the
    // normal class, so keep that class for light traffic.
    always_comb begin
        logic ok;
        ok      = 1'b0;
        win     = '0;
        win_idx = 4'h0;
        // High requests compete among themselves
        if (|(req_in & high)) begin
            cand = req_in & high;
        end else begin
            cand = req_in;
        end
        // A candidate wins when older than all others;
        // the age order is total, so exactly one passes
        for (int i = 0; i < PORTS; i++) begin
            ok = cand[i];
            for (int j = 0; j < PORTS; j++) begin
                if (j != i && cand[j] && !s_q.older[i][j]) begin
                    ok = 1'b0;
                end
            end
            if (ok) begin
                win[i]  = 1'b1;
                win_idx = 4'(i);
            end
        end
    end

    assign any_win   = |win;
    assign grant_out = win;

    // ****************************************************************
    // Permission check of the winner
    // ****************************************************************
    // Only the winner is judged; losers just wait
    assign pif.addr  = addr_in[win_idx];
    assign pif.group = s_q.group[win_idx];
    assign pif.masks = s_q.masks;

    sba_perm_check u_perm (
        .pif (pif.chk)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [31:0] rd;
        logic [31:0] ridx;
        logic        reg_hit;
        rd      = '0;
        // Region masks sit one word apart
        ridx    = 32'((reg_addr_in - OFS_REGION) >> 2);
        reg_hit = (reg_addr_in >= OFS_REGION) && (reg_addr_in[1:0] == 2'b00)
                  && (ridx < NUM_REGIONS);
        s_d        = s_q;
        s_d.tvalid = 1'b0;
        s_d.viol   = 1'b0;
        s_d.rdata  = '0;
        // Pulses and read data fall to zero unless set

        // Grant bookkeeping: winner becomes the most recently served
        if (any_win) begin
            // Only CPU and DMA own a second, high id;
            // flash keeps its single one
            s_d.gid = ID_NORMAL[win_idx];
            if (high[win_idx] && win_idx <= 4'(P_DMAW)) begin
                s_d.gid = 4'(ID_NORMAL[win_idx] + ID_HIGH_STEP);
            end
            // Refused accesses age too, so a blocked
            // initiator cannot hold the bus by retrying
            s_d.taddr  = addr_in[win_idx];
            s_d.tvalid = pif.allow;
            s_d.viol   = !pif.allow;
            // Winner becomes youngest against every port
            for (int j = 0; j < PORTS; j++) begin
                if (j != 32'(win_idx)) begin
                    s_d.older[win_idx][j] = 1'b0;
                    s_d.older[j][win_idx] = 1'b1;
                end
            end
        end

        // Register writes
        if (reg_wr_in) begin
            // Any write other than the second key breaks the sequence
            if (s_q.unl == UNL_KEY1) begin
                s_d.unl = UNL_IDLE;
            end
            case (reg_addr_in)
                OFS_CONFIG: begin
                    // Priority bits move freely; lock needs keys
                    s_d.dma_pri = reg_wdata_in[CFG_DMA_PRI_BIT];
                    s_d.cpu_pri = reg_wdata_in[CFG_CPU_PRI_BIT];
                    // Lock bit moves only once the sequence has armed it
                    if (s_q.unl == UNL_OPEN) begin
                        s_d.lock = reg_wdata_in[CFG_LOCK_BIT];
                        s_d.unl  = UNL_IDLE;
                    end
                end
                OFS_UNLOCK: begin
                    // Key port stores nothing; it steers only
                    if (reg_wdata_in == UNLOCK_KEY1) begin
                        s_d.unl = UNL_KEY1;
                    end else if (s_q.unl == UNL_KEY1 && reg_wdata_in == UNLOCK_KEY2) begin
                        s_d.unl = UNL_OPEN;
                    end else begin
                        // A wrong key disarms
                        s_d.unl = UNL_IDLE;
                    end
                end
                OFS_GROUP: begin
                    // Field p holds the group of port p
                    if (!s_q.lock) begin
                        s_d.group = reg_wdata_in[PORTS*GRP_W-1:0];
                    end
                end
                OFS_STATUS: begin
                    // Write one clears the sticky flag
                    // Violator id and armed bit are read-only
                    if (reg_wdata_in[ST_VIOL_BIT]) begin
                        s_d.viol_sticky = 1'b0;
                    end
                end
                default: begin
                    // Region masks; other addresses ignored
                    if (reg_hit && !s_q.lock) begin
                        s_d.masks[ridx[3:0]] = reg_wdata_in[NUM_GROUPS-1:0];
                    end
                end
            endcase
        end

        // A violation in the clearing cycle still sets the flag
        // The id is the one just worked out for this grant
        if (any_win && !pif.allow) begin
            s_d.viol_sticky = 1'b1;
            s_d.viol_id     = s_d.gid;
        end

        // Register reads, answered next cycle
        // Only live fields read back; spare bits are zero
        if (reg_rd_in) begin
            case (reg_addr_in)
                OFS_CONFIG: begin
                    rd[CFG_DMA_PRI_BIT] = s_q.dma_pri;
                    rd[CFG_CPU_PRI_BIT] = s_q.cpu_pri;
                    rd[CFG_LOCK_BIT]    = s_q.lock;
                end
                OFS_GROUP: begin
                    rd[PORTS*GRP_W-1:0] = s_q.group;
                end
                OFS_STATUS: begin
                    rd[ST_VIOL_BIT]              = s_q.viol_sticky;
                    rd[ST_ID_LSB+ID_W-1:ST_ID_LSB] = s_q.viol_id;
                    rd[ST_OPEN_BIT]              = (s_q.unl == UNL_OPEN);
                end
                default: begin
                    // Key port and unmapped space read zero
                    if (reg_hit) begin
                        rd[NUM_GROUPS-1:0] = s_q.masks[ridx[3:0]];
                    end
                end
            endcase
            s_d.rdata = rd;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    // Reset: lowest port counts as oldest, all groups in group 0,
    // every region open to every group, lock clear
    // Reset is synchronous; one edge is enough
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_q <= '0;
            for (int i = 0; i < PORTS; i++) begin
                for (int j = 0; j < PORTS; j++) begin
                    s_q.older[i][j] <= (i < j);
                end
            end
            for (int r = 0; r < NUM_REGIONS; r++) begin
                s_q.masks[r] <= REGION_MASK_RST;
            end
            s_q.unl <= UNL_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Data outputs come from flip-flops; only grant_out
    // is combinational, for a same-cycle handshake
    assign grant_id_out     = s_q.gid;
    assign target_valid_out = s_q.tvalid;
    assign target_addr_out  = s_q.taddr;
    assign violation_out    = s_q.viol;
    assign reg_rdata_out    = s_q.rdata;

endmodule

// *** test/sba_bus_arbiter_asserts.sv ***
// Purpose: Port level checks of the arbiter.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Ports 3 and flash stand in for their classes.
`timescale 1ns/100ps
module sba_bus_arbiter_asserts
    import sba_pkg::*;
#(
    parameter int PORTS = NUM_PORTS  // Initiator ports
)(
    // Clock and reset
    input wire logic                         clk_in,
    input wire logic                         rst_in,
    // Arbitration
    input wire logic [PORTS-1:0]             req_in,
    input wire logic [PORTS-1:0][ADDR_W-1:0] addr_in,
    input wire logic [PORTS-1:0]             grant_out,
    input wire logic [ID_W-1:0]              grant_id_out,
    input wire logic                         target_valid_out,
    input wire logic [ADDR_W-1:0]            target_addr_out,
    input wire logic                         violation_out
);
    // ****
    // Checks, all on the one clock
    // ****
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_ONE_GRANT: assert property ($onehot0(grant_out))
        else $error("more than one grant");
    AST_GRANT_REQ: assert property ((grant_out & ~req_in) == '0)
        else $error("grant without request");
    AST_NO_IDLE: assert property (|req_in |-> |grant_out)
        else $error("request left idle");
    AST_FLASH_FIRST: assert property (req_in[P_FLASH] && !(|req_in[P_DMAW:P_CPU])
        |-> grant_out[P_FLASH]) else $error("flash not first");
    AST_FLASH_ID: assert property (grant_out[P_FLASH] |=> grant_id_out == 4'hd)
        else $error("flash id wrong");
    AST_CPU_ID: assert property (grant_out[P_CPU] |=> grant_id_out inside {4'h1, 4'h2})
        else $error("cpu id wrong");
    AST_OUTCOME: assert property (|grant_out |=> target_valid_out != violation_out)
        else $error("grant outcome wrong");
    AST_QUIET: assert property (!(|grant_out) |=> !target_valid_out && !violation_out)
        else $error("outcome without grant");
    AST_ADDR: assert property (grant_out[3] |=> target_addr_out == $past(addr_in[3]))
        else $error("target address wrong");
    AST_BAD_REGION: assert property (grant_out[3] && addr_in[3][31:28] > 4'hd
        |=> violation_out) else $error("missing region passed");
endmodule

bind sba_bus_arbiter sba_bus_arbiter_asserts #(.PORTS(PORTS)) u_sba_bus_arbiter_asserts (
    .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .addr_in(addr_in),
    .grant_out(grant_out), .grant_id_out(grant_id_out), .target_valid_out(target_valid_out),
    .target_addr_out(target_addr_out), .violation_out(violation_out));

// *** test/sba_initiator_model.sv ***
// Purpose: Bus initiators that hold a request until granted.
// Assumes: Bench launches a request set with one address.
// Notes:   Released address lines show the inverse of the last value.
`timescale 1ns/100ps
module sba_initiator_model
    import sba_pkg::*;
#(
    parameter int PORTS = NUM_PORTS  // Initiator ports
)(
    // Clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    // Bench commands
    input  wire logic [PORTS-1:0]             launch_in,
    input  wire logic [ADDR_W-1:0]            launch_addr_in,
    // Arbiter side
    input  wire logic [PORTS-1:0]             grant_in,
    output logic      [PORTS-1:0]             req_out,
    output logic      [PORTS-1:0][ADDR_W-1:0] addr_out
);
    // ****
    // Request holding
    // ****
    always_ff @(posedge clk_in) begin
        for (int p = 0; p < PORTS; p++) begin
            if (rst_in) begin
                req_out[p]  <= 1'b0;
                addr_out[p] <= '0;
            end else if (launch_in[p]) begin
                req_out[p]  <= 1'b1;
                addr_out[p] <= launch_addr_in;
            end else if (grant_in[p]) begin
                // Released lines must not keep a stale address
                req_out[p]  <= 1'b0;
                addr_out[p] <= ~addr_out[p];
            end
        end
    end
endmodule

// *** test/sba_bus_arbiter_test.sv ***
// Purpose: Self-checking bench of the arbiter.
// Assumes: Initiator model holds requests until granted.
// Notes:   All grants of a launch are collected before the next.
`timescale 1ns/100ps
module sba_bus_arbiter_test
    import sba_pkg::*;
;
    // ****
    // Bench signals
    // ****
    logic                                clk_in = 1'b0;
    logic                                rst_in = 1'b1;
    logic [NUM_PORTS-1:0]                launch = '0;
    logic [ADDR_W-1:0]                   launch_addr = '0;
    logic [NUM_PORTS-1:0]                req;
    logic [NUM_PORTS-1:0][ADDR_W-1:0]    addr;
    logic [NUM_PORTS-1:0]                grant;
    logic [ID_W-1:0]                     gid;
    logic                                tv;
    logic                                viol;
    logic                                exception_level_flag = 1'b0;
    logic [REG_AW-1:0]                   ra = '0;
    logic [31:0]                         wd = '0;
    logic                                wr_s = 1'b0;
    logic                                rd_s = 1'b0;
    logic [31:0]                         rdata;
    int                                  bad_count = 0;
    int                                  checked = 0;

    always #10 clk_in = ~clk_in;

    sba_bus_arbiter #(.PORTS(NUM_PORTS)) u_sba_bus_arbiter (
        .clk_in(clk_in), .rst_in(rst_in), .req_in(req), .addr_in(addr), .exl_in(exception_level_flag),
        .grant_out(grant), .grant_id_out(gid), .target_valid_out(tv),
        .target_addr_out(), .violation_out(viol), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata));
    sba_initiator_model #(.PORTS(NUM_PORTS)) u_sba_initiator_model (
        .clk_in(clk_in), .rst_in(rst_in), .launch_in(launch), .launch_addr_in(launch_addr),
        .grant_in(grant), .req_out(req), .addr_out(addr));

    // ****
    // Tasks
    // ****
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr_s <= 1'b1;
        ra   <= a;
        wd   <= d;
        @(posedge clk_in);
        wr_s <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        rd_s <= 1'b1;
        ra   <= a;
        @(posedge clk_in);
        rd_s <= 1'b0;
        #1 chk("reg_rdata_out", exp, rdata);
    endtask

    task automatic go(input logic [NUM_PORTS-1:0] m, input logic [31:0] a);
        @(posedge clk_in);
        launch      <= m;
        launch_addr <= a;
        @(posedge clk_in);
        launch      <= '0;
    endtask

    // Grant is combinational, so it is looked at mid cycle
    task automatic grab(input int p, input logic [3:0] id, input logic ok);
        int n;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
        end while (grant === '0 && n < 20);
        chk("grant_out", 32'h1 << p, 32'(grant));
        if (grant === '0) tally_and_finish();
        @(posedge clk_in);
        #1 chk("grant_id_out", 32'(id), 32'(gid));
        chk("target_valid_out", 32'(ok), 32'(tv));
        chk("violation_out", 32'(!ok), 32'(viol));
    endtask

    // ****
    // Scenarios
    // ****
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_GROUP, 32'h0);
        rd(OFS_REGION, 32'hf);
        rd(OFS_REGION + 8'h34, 32'hf);
        rd(8'h78, 32'h0);
        go(11'h008, 32'h1000_0000);
        grab(3, 4'h7, 1'b1);
        go(11'h018, 32'h1000_0000);
        grab(4, 4'h8, 1'b1);
        grab(3, 4'h7, 1'b1);
        go(11'h620, 32'h2000_0000);
        grab(9, 4'hd, 1'b1);
        grab(5, 4'h9, 1'b1);
        grab(10, 4'he, 1'b1);
        go(11'h002, 32'h0000_0100);
        grab(1, 4'h3, 1'b1);
        go(11'h00a, 32'h0000_0100);
        grab(3, 4'h7, 1'b1);
        grab(1, 4'h3, 1'b1);
        wr(OFS_CONFIG, 32'h1 << CFG_DMA_PRI_BIT);
        go(11'h00a, 32'h0000_0100);
        grab(1, 4'h4, 1'b1);
        grab(3, 4'h7, 1'b1);
        wr(OFS_CONFIG, 32'h1 << CFG_CPU_PRI_BIT);
        go(11'h001, 32'h0000_0100);
        grab(0, 4'h1, 1'b1);
        @(posedge clk_in);
        exception_level_flag <= 1'b1;
        go(11'h009, 32'h0000_0100);
        grab(0, 4'h2, 1'b1);
        grab(3, 4'h7, 1'b1);
        wr(OFS_GROUP, 32'h80);
        wr(OFS_REGION + 8'h04, 32'h4);
        go(11'h008, 32'h1000_0000);
        grab(3, 4'h7, 1'b1);
        go(11'h010, 32'h1000_0000);
        grab(4, 4'h8, 1'b0);
        rd(OFS_STATUS, 32'h0801);
        go(11'h008, 32'he000_0000);
        grab(3, 4'h7, 1'b0);
        wr(OFS_CONFIG, 32'h0100_0800);
        rd(OFS_CONFIG, 32'h0100_0000);
        wr(OFS_UNLOCK, UNLOCK_KEY1);
        wr(OFS_UNLOCK, UNLOCK_KEY2);
        rd(OFS_STATUS, 32'h0001_0701);
        wr(OFS_CONFIG, 32'h0100_0800);
        rd(OFS_CONFIG, 32'h0100_0800);
        wr(OFS_GROUP, 32'h0);
        rd(OFS_GROUP, 32'h80);
        wr(OFS_REGION + 8'h04, 32'hf);
        rd(OFS_REGION + 8'h04, 32'h4);
        go(11'h010, 32'h1000_0000);
        grab(4, 4'h8, 1'b0);
        tally_and_finish();
    end
endmodule
